// ---- ipc_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the interrupt positioner.
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
`define IPC_OFS_CTRL      8'h00
`define IPC_OFS_LENGTH    8'h04
`define IPC_OFS_SPEED     8'h08
`define IPC_OFS_RAMP      8'h0C
`define IPC_OFS_GEAR      8'h10
`define IPC_OFS_STATE     8'h14
`define IPC_OFS_REMAIN    8'h18
`define IPC_OFS_INT_STAT  8'h1C
`define IPC_OFS_INT_MASK  8'h20
`define IPC_MODE_LSB      0
`define IPC_FUNC8_LSB     8
`define IPC_DIRCFG_LSB    16
`define IPC_SHIFT_LSB     16
`define IPC_CTRL_RST      32'h0000_0000
`define IPC_SPEED_RST     16'h0000
`define IPC_RAMP_RST      16'h0000
`define IPC_GEAR_RST      32'h0000_0001
`define IPC_TRIG_FUNC     8'h22
`define IPC_EV_START      0
`define IPC_EV_DONE       1
`define IPC_EV_ABORT      2
`define IPC_TICK_US       1000
`define IPC_CLK_MHZ       100
`define IPC_TICK_CYCLES   (`IPC_TICK_US * `IPC_CLK_MHZ)
`endif

// ---- ipc_pkg.sv ----
// Types shared by the interrupt positioner and its bench.
package ipc_pkg;
    typedef enum logic [1:0] {
        IPC_IDLE = 2'b00,
        IPC_RUN  = 2'b01,
        IPC_HOLD = 2'b10
    } ipc_state_type;

    typedef struct packed {
        logic input_terminal_eight;
        logic input_terminal_nine;
        logic interrupt_unlock_in;
        logic interrupt_prohibit_in;
    } ipc_din_type;

    typedef struct packed {
        logic pos_mode;
        logic cur_dir_neg;
        logic cmd_zero;
    } ipc_host_type;

    typedef struct packed {
        logic        override_active;
        logic        move_active;
        logic        move_done;
        logic        move_dir_neg;
        logic [15:0] move_increment;
        logic        move_tick;
    } ipc_move_type;
endpackage : ipc_pkg

// ---- ipc_interrupt_positioner.sv ----
// Interrupt positioning sequencer with APB register access.
// Function
// [R1] Interrupt move preempts running position command
// [R2] Move length is signed 32-bit length setting
// [R3] Move runs at the speed setting
// [R4] Ramp uses the ramp time setting
// [R5] Mode zero ignores trigger entirely
// [R6] Modes 1,2 rising edge; 3,4 falling
// [R7] Modes 1,3 auto release; 2,4 unlock
// [R8] Trigger taken only from terminal eight
// [R9] Host maps trigger function to terminal
// [R10] Unlock input releases held interrupt state
// [R11] Prohibit input blocks interrupt moves
// [R12] Completion output asserted after move finishes
// [R13] In-progress output high while moving
// [R14] Direction rule from second decimal digit
// [R15] Follow rule: match positive, else negative
// [R16] Sign rule: direction from increment sign
// [R17] Zero command: move along increment sign
// [R18] Length scaled through electronic gear ratio
// [R19] Inputs synchronised; one edge per interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ipc_cfg.svh"
module ipc_interrupt_positioner #(
    parameter int TICK_CYCLES = `IPC_TICK_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Terminals and drive status
    input  wire ipc_pkg::ipc_din_type  din,
    input  wire ipc_pkg::ipc_host_type host,
    // Move command and interrupt
    output ipc_pkg::ipc_move_type      move,
    output logic                       irq
);
    import ipc_pkg::*;

    // Sequencer and registers.
    ipc_state_type state_reg;
    logic [31:0]   ctrl_reg;
    logic [31:0]   length_reg;
    logic [15:0]   speed_reg;
    logic [15:0]   ramp_reg;
    logic [31:0]   gear_reg;
    logic [2:0]    int_stat_reg;
    logic [2:0]    int_mask_reg;

    // Synchronisers.
    logic [3:0]    sync1_reg;
    logic [3:0]    sync2_reg;
    logic          trig_prev_reg;

    // Motion profile.
    logic [31:0]   remain_reg;
    logic [31:0]   ramp_dist_reg;
    logic [31:0]   acc_reg;
    logic [15:0]   vel_reg;
    logic [31:0]   tick_cnt_reg;
    logic          done_reg;
    logic          dir_neg_reg;

    // Output flops.
    ipc_move_type  move_reg;
    logic [31:0]   prdata_reg;
    logic          pready_reg;
    logic          pslverr_reg;
    logic          irq_reg;

    // Control fields.
    logic [2:0]    mode;
    logic [7:0]    func8;
    logic [15:0]   dir_cfg;
    logic          rule_sign;

    // Trigger path.
    logic          trig_s;
    logic          unlock_s;
    logic          prohibit_s;
    logic          rise;
    logic          fall;
    logic          start;
    logic          tick;
    logic          decel;

    // Profile helpers.
    logic [31:0]   abs_len;
    logic [47:0]   scaled;
    logic [31:0]   enc_len;
    logic [31:0]   step;

    // Bus decode.
    logic          wr_en;
    logic          rd_en;
    logic          rd_stat;
    logic [2:0]    ev;
    logic          mapped;
    logic [31:0]   rd_mux;

    assign mode      = ctrl_reg[`IPC_MODE_LSB +: 3];
    assign func8     = ctrl_reg[`IPC_FUNC8_LSB +: 8];
    assign dir_cfg   = ctrl_reg[`IPC_DIRCFG_LSB +: 16];
    // Second decimal digit from the right; only 0 or 1 are meaningful, others use sign rule.
    assign rule_sign = ((dir_cfg / 16'd10) % 16'd10) != 16'd0; // [R14]

    // Stage two of each synchroniser is the only consumer of stage one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg     <= 4'h0;
            sync2_reg     <= 4'h0;
            trig_prev_reg <= 1'b0;
        end else if (ce) begin
            // Order: terminal eight, nine, unlock, prohibit.
            sync1_reg     <= {din.input_terminal_eight, din.input_terminal_nine,
                              din.interrupt_unlock_in, din.interrupt_prohibit_in}; // [R19]
            sync2_reg     <= sync1_reg;
            trig_prev_reg <= sync2_reg[3];
        end
    end

    // Terminal nine is synchronised but never triggers a move.
    assign trig_s     = sync2_reg[3]; // [R8]
    assign unlock_s   = sync2_reg[1];
    assign prohibit_s = sync2_reg[0];
    assign rise       = trig_s & ~trig_prev_reg;
    assign fall       = ~trig_s & trig_prev_reg;

    // Edges only count while idle, so a move is started once per interrupt.
    always_comb begin
        start = 1'b0;
        if (state_reg == IPC_IDLE && host.pos_mode && !prohibit_s // [R11] [R19]
            && func8 == `IPC_TRIG_FUNC) begin // [R8]
            unique case (mode)
                3'd1, 3'd2: start = rise; // [R6]
                3'd3, 3'd4: start = fall; // [R6]
                default:    start = 1'b0; // [R5]
            endcase
        end
    end

    // Move length scaled to encoder counts by gear numerator and right shift.
    // Bits above 31 are dropped; the shift sets ratios below one.
    assign abs_len = length_reg[31] ? (~length_reg + 32'h0000_0001) : length_reg; // [R2]
    assign scaled  = (48'(abs_len) * 48'(gear_reg[15:0])) >> gear_reg[`IPC_SHIFT_LSB +: 5];
    assign enc_len = scaled[31:0]; // [R18]

    // Profile tick; speed is issued in counts per tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
                tick_cnt_reg <= 32'h0000_0000;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            end
        end
    end
    assign tick  = tick_cnt_reg >= 32'(TICK_CYCLES - 1);
    assign decel = remain_reg <= ramp_dist_reg;
    assign step  = (32'(vel_reg) < remain_reg) ? 32'(vel_reg) : remain_reg;

    // Sequencer state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IPC_IDLE;
            done_reg  <= 1'b0;
        end else if (ce) begin
            unique case (state_reg)
                IPC_IDLE: begin
                    if (start) begin
                        state_reg <= IPC_RUN; // [R1]
                        done_reg  <= 1'b0;
                    end
                end

                IPC_RUN: begin
                    if (prohibit_s || !host.pos_mode) begin
                        state_reg <= IPC_IDLE; // [R11]
                    end else if (remain_reg == 32'h0000_0000) begin
                        done_reg <= 1'b1; // [R12]
                        if (mode == 3'd2 || mode == 3'd4) begin
                            state_reg <= IPC_HOLD; // [R7]
                        end else begin
                            state_reg <= IPC_IDLE; // [R7]
                        end
                    end
                end

                IPC_HOLD: begin
                    // A trigger edge here is ignored until release.
                    if (unlock_s) begin
                        state_reg <= IPC_IDLE; // [R10]
                    end
                end
                default: state_reg <= IPC_IDLE;
            endcase
        end
    end

    // Direction captured at the start of each move.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_neg_reg <= 1'b0;
        end else if (ce && start) begin
            // A zero running command has no direction to follow.
            if (host.cmd_zero) begin
                dir_neg_reg <= length_reg[31]; // [R17]
            end else if (rule_sign) begin
                dir_neg_reg <= length_reg[31]; // [R16]
            end else begin
                dir_neg_reg <= host.cur_dir_neg ^ length_reg[31]; // [R15]
            end
        end
    end

    // Trapezoid profile: velocity steps by one each time the accumulated
    // speed-per-tick reaches the ramp time, so full speed is met after ramp ticks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_reg    <= 32'h0000_0000;
            ramp_dist_reg <= 32'h0000_0000;
            acc_reg       <= 32'h0000_0000;
            vel_reg       <= 16'h0000;
        end else if (ce) begin
            if (start) begin
                remain_reg    <= enc_len;
                ramp_dist_reg <= 32'h0000_0000;
                acc_reg       <= 32'h0000_0000;
                vel_reg       <= (ramp_reg == 16'h0000) ? speed_reg : 16'h0001; // [R3] [R4]
            end else if (state_reg == IPC_RUN) begin
                // Ticks spend counts; cycles between them move the velocity.
                if (tick) begin
                    remain_reg <= remain_reg - step;
                    acc_reg    <= acc_reg + 32'(speed_reg); // [R4]
                    if (!decel && vel_reg < speed_reg) begin
                        ramp_dist_reg <= ramp_dist_reg + 32'(vel_reg);
                    end
                end else if (ramp_reg != 16'h0000 && acc_reg >= 32'(ramp_reg)) begin
                    acc_reg <= acc_reg - 32'(ramp_reg);
                    if (decel) begin
                        if (vel_reg > 16'h0001) begin
                            vel_reg <= vel_reg - 16'h0001; // [R4]
                        end
                    end else if (vel_reg < speed_reg) begin
                        vel_reg <= vel_reg + 16'h0001; // [R3]
                    end
                end
            end else begin
                // The next move starts again from the ramp floor.
                vel_reg <= 16'h0000;
            end
        end
    end

    // Move command outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            move_reg <= '0;
        end else if (ce) begin
            move_reg.override_active <= state_reg != IPC_IDLE; // [R1]
            move_reg.move_active     <= state_reg == IPC_RUN; // [R13]
            move_reg.move_done       <= done_reg; // [R12]
            move_reg.move_dir_neg    <= dir_neg_reg;
            // Tick and increment mark the same profile step.
            move_reg.move_tick       <= tick && state_reg == IPC_RUN;
            move_reg.move_increment  <= (tick && state_reg == IPC_RUN) ? step[15:0] : 16'h0000;
        end
    end

    // APB: zero-wait slave, answer registered during the setup cycle.
    // Read data is taken at setup, so status may still change before the access edge.
    assign wr_en   = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    assign rd_en   = psel & penable & pready_reg & ~pwrite;
    assign rd_stat = rd_en && paddr == `IPC_OFS_INT_STAT;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        // Unmapped offsets read zero and raise the error flag.
        unique case (paddr)
            `IPC_OFS_CTRL:     rd_mux = ctrl_reg;
            `IPC_OFS_LENGTH:   rd_mux = length_reg;
            `IPC_OFS_SPEED:    rd_mux = {16'h0000, speed_reg};
            `IPC_OFS_RAMP:     rd_mux = {16'h0000, ramp_reg};
            `IPC_OFS_GEAR:     rd_mux = gear_reg;
            `IPC_OFS_STATE:    rd_mux = {28'h0000000, dir_neg_reg, done_reg, state_reg};
            `IPC_OFS_REMAIN:   rd_mux = remain_reg;
            `IPC_OFS_INT_STAT: rd_mux = {29'h00000000, int_stat_reg};
            `IPC_OFS_INT_MASK: rd_mux = {29'h00000000, int_mask_reg};
            default:           mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            // Ready never re-arms while penable is high.
            pready_reg  <= psel & ~penable;
            if (psel && !penable) begin
                prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_reg <= ~mapped;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= `IPC_CTRL_RST;
            length_reg   <= 32'h0000_0000;
            speed_reg    <= `IPC_SPEED_RST;
            ramp_reg     <= `IPC_RAMP_RST;
            gear_reg     <= `IPC_GEAR_RST;
            int_mask_reg <= 3'h0;
        end else if (ce && wr_en) begin
            // State, remaining length and status are read-only.
            unique case (paddr)
                `IPC_OFS_CTRL:     ctrl_reg     <= pwdata;
                `IPC_OFS_LENGTH:   length_reg   <= pwdata; // [R2]
                `IPC_OFS_SPEED:    speed_reg    <= pwdata[15:0];
                `IPC_OFS_RAMP:     ramp_reg     <= pwdata[15:0];
                `IPC_OFS_GEAR:     gear_reg     <= pwdata;
                `IPC_OFS_INT_MASK: int_mask_reg <= pwdata[2:0];
                default:           ;
            endcase
        end
    end

    // Sticky events; a read clears only the bits it returned.
    always_comb begin
        ev = 3'h0;
        // Done and abort exclude each other by their terms.
        ev[`IPC_EV_START] = start;
        ev[`IPC_EV_DONE]  = state_reg == IPC_RUN && remain_reg == 32'h0000_0000
                            && !prohibit_s && host.pos_mode;
        ev[`IPC_EV_ABORT] = state_reg == IPC_RUN && (prohibit_s || !host.pos_mode);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_reg <= 3'h0;
            irq_reg      <= 1'b0;
        end else if (ce) begin
            int_stat_reg <= (rd_stat ? (int_stat_reg & ~prdata_reg[2:0]) : int_stat_reg) | ev;
            irq_reg      <= |(((rd_stat ? (int_stat_reg & ~prdata_reg[2:0]) : int_stat_reg) | ev)
                              & int_mask_reg);
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign move    = move_reg;
    assign irq     = irq_reg;
endmodule : ipc_interrupt_positioner
`default_nettype wire

// ---- ipc_checker_props.sv ----
// Port-level checker for the interrupt positioner, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module ipc_checker_props #(
    parameter int TICK_CYCLES = 8
) (
    // Clock, reset and enable
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  ce,
    // Register bus
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Terminals, drive status and move command
    input wire ipc_pkg::ipc_din_type  din,
    input wire ipc_pkg::ipc_host_type host,
    input wire ipc_pkg::ipc_move_type move,
    input wire logic                  irq
);
    import ipc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_setup_ready; psel && !penable && ce |=> pready; endproperty
    a_setup_ready: assert property (p_setup_ready) else $error("no answer after setup");
    property p_ready_once; pready && ce |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held too long");
    property p_active_ovr; move.move_active |-> move.override_active; endproperty
    a_active_ovr: assert property (p_active_ovr) else $error("moving without override");
    property p_tick_run; move.move_tick |-> move.move_active; endproperty
    a_tick_run: assert property (p_tick_run) else $error("tick outside a move");
    property p_inc_tick; move.move_increment != 16'h0 |-> move.move_tick; endproperty
    a_inc_tick: assert property (p_inc_tick) else $error("counts without tick");
    // Prohibit passes two sync flops, the state flop and the output flop before the move stops; six cycles leave margin.
    property p_prohibit; din.interrupt_prohibit_in [*6] |=> !move.move_active; endproperty
    a_prohibit: assert property (p_prohibit) else $error("move under prohibit");
    property p_posmode; !host.pos_mode [*3] |=> !move.move_active; endproperty
    a_posmode: assert property (p_posmode) else $error("move outside position mode");
    property p_done_idle; move.move_done |-> !move.move_active; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while moving");
    property p_dir_stable; move.move_active && $past(move.move_active) |-> $stable(move.move_dir_neg); endproperty
    a_dir_stable: assert property (p_dir_stable) else $error("direction changed mid-move");
    property p_start_run; $rose(move.override_active) |-> move.move_active; endproperty
    a_start_run: assert property (p_start_run) else $error("override without run");
endmodule : ipc_checker_props
bind ipc_interrupt_positioner ipc_checker_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din(din), .host(host), .move(move), .irq(irq)
);
`default_nettype wire

// ---- ipc_terminal_host.sv ----
// Upper-controller model that drives the input terminals and drive status levels.
`timescale 1ns/1ps
`default_nettype none
module ipc_terminal_host (
    // Clock
    input  wire logic             pclk,
    // Terminal levels and drive status
    output ipc_pkg::ipc_din_type  din,
    output ipc_pkg::ipc_host_type host
);
    import ipc_pkg::*;
    initial begin
        din = '0;
        host = 3'h4;
    end
    // Bit 3 is terminal eight, the only trigger source; bit 1 unlock, bit 0 prohibit.
    // A level must stand across at least one clock edge or the synchronisers may never see it.
    task automatic pin(input int idx, input logic lvl, input int hold);
        din[idx] <= lvl;
        repeat (hold) @(posedge pclk);
    endtask : pin
    task automatic drive_status(input logic pm, input logic cur_neg, input logic zero);
        host <= {pm, cur_neg, zero};
    endtask : drive_status
endmodule : ipc_terminal_host
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the interrupt positioner.
`timescale 1ns/1ps
`default_nettype none
`include "ipc_cfg.svh"
module testbench;
    import ipc_pkg::*;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         irq;
    ipc_din_type  din;
    ipc_host_type host;
    ipc_move_type move;
    logic [31:0]  sum;
    logic [15:0]  first;
    logic [15:0]  maxv;
    int           errors = 0;
    int           total_checks = 0;
    int           cycles = 0;
    ipc_interrupt_positioner #(.TICK_CYCLES(8)) uut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .din(din), .host(host), .move(move), .irq(irq)
    );
    ipc_terminal_host u_host (.pclk(pclk), .din(din), .host(host));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp, what);
    endtask : rdc
    function automatic logic exp_dir(input logic [31:0] len, input logic cur, input logic zero,
                                     input logic [15:0] cfg);
        if (zero || (cfg / 16'hA) % 16'hA != 16'h0) return len[31];
        return cur ^ len[31];
    endfunction : exp_dir
    // Counts are summed on every edge; outside ticks the increment is zero anyway.
    task automatic step();
        @(posedge pclk);
        if (move.move_increment != 16'h0) begin
            if (first === 16'h0) first = move.move_increment;
            if (move.move_increment > maxv) maxv = move.move_increment;
            sum = sum + {16'h0, move.move_increment};
        end
    endtask : step
    task automatic run_mode(input logic [2:0] m);
        logic        idle;
        logic        ed;
        logic [31:0] mag;
        logic [31:0] len;
        logic [31:0] gn;
        logic [15:0] spd;
        logic [15:0] rmp;
        logic [15:0] cfg;
        logic        cur;
        logic        zero;
        int          n;
        idle = m > 3'h2;
        mag = 32'h5 + 32'($urandom % 36);
        len = ($urandom % 2) ? -mag : mag;
        gn = 32'h1 + 32'($urandom % 3);
        spd = 16'h1 + 16'($urandom % 6);
        rmp = 16'($urandom % 3);
        cfg = 16'(($urandom % 3) * 10 + $urandom % 10);
        cur = 1'($urandom % 2);
        zero = 1'($urandom % 2);
        ed = exp_dir(len, cur, zero, cfg);
        wr(`IPC_OFS_CTRL, {24'h22, 5'h0, m[0] ? m + 3'h4 : 3'h0});
        u_host.pin(3, !idle, 6);
        u_host.pin(3, idle, 6);
        check(move.override_active, 1'b0, "start in unused mode");
        wr(`IPC_OFS_LENGTH, len);
        wr(`IPC_OFS_SPEED, {16'h0, spd});
        wr(`IPC_OFS_RAMP, {16'h0, rmp});
        wr(`IPC_OFS_GEAR, gn);
        wr(`IPC_OFS_INT_MASK, m[0] ? 32'h7 : 32'h0);
        u_host.drive_status(1'b1, cur, zero);
        wr(`IPC_OFS_CTRL, {cfg, 8'h22, 5'h0, m});
        u_host.pin(2, 1'b1, 6);
        u_host.pin(2, 1'b0, 6);
        check(move.override_active, 1'b0, "start from terminal nine");
        if (m[0]) u_host.pin(0, 1'b1, 2);
        else u_host.drive_status(1'b0, cur, zero);
        u_host.pin(3, !idle, 6);
        u_host.pin(3, idle, 6);
        u_host.drive_status(1'b1, cur, zero);
        u_host.pin(0, 1'b0, 6);
        check(move.override_active, 1'b0, "start while blocked");
        sum = 32'h0;
        first = 16'h0;
        maxv = 16'h0;
        n = 0;
        u_host.pin(3, !idle, 0);
        while (move.move_active !== 1'b1 && n < 30) begin
            step();
            n++;
        end
        check(move.move_dir_neg, ed, "move direction");
        while (move.move_active === 1'b1 && n < 3000) begin
            step();
            n++;
        end
        repeat (2) step();
        check(sum, mag * gn, "total counts");
        check({16'h0, first}, rmp != 16'h0 ? 32'h1 : ({16'h0, spd} < mag * gn ? {16'h0, spd}
              : mag * gn), "first step");
        check(maxv > spd, 1'b0, "step above speed");
        check(move.move_done, 1'b1, "completion output");
        if (m[0]) begin
            u_host.pin(3, idle, 8);
            check(move.override_active, 1'b0, "auto release");
        end else begin
            repeat (8) @(posedge pclk);
            check(move.override_active, 1'b1, "held until unlock");
            rdc(`IPC_OFS_STATE, {28'h0, ed, 1'b1, 2'h2}, "held state");
            u_host.pin(1, 1'b1, 6);
            u_host.pin(1, 1'b0, 0);
            check(move.override_active, 1'b0, "unlock release");
        end
        check(irq, m[0], "interrupt level");
        rdc(`IPC_OFS_INT_STAT, 32'h3, "event status");
        repeat (2) @(posedge pclk);
        check(irq, 1'b0, "interrupt after clear");
    endtask : run_mode
    initial begin
        logic [31:0] rd;
        logic        err;
        logic [7:0]  ofs [7];
        logic [31:0] rv [7];
        void'($urandom(45879));
        ofs = '{`IPC_OFS_CTRL, `IPC_OFS_LENGTH, `IPC_OFS_SPEED, `IPC_OFS_RAMP,
                `IPC_OFS_GEAR, `IPC_OFS_INT_MASK, `IPC_OFS_STATE};
        rv = '{`IPC_CTRL_RST, 32'h0, 32'h0, 32'h0, `IPC_GEAR_RST, 32'h0, 32'h0};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rdc(ofs[i], rv[i], "reset value");
        apb(1'b0, 8'h40, 32'h0, rd, err);
        check(err, 1'b1, "unmapped error flag");
        check(rd, 32'h0, "unmapped read data");
        wr(`IPC_OFS_STATE, 32'hFFFF_FFFF);
        rdc(`IPC_OFS_STATE, 32'h0, "read-only state");
        for (int p = 0; p < 2; p++) begin
            for (int m = 1; m < 5; m++) run_mode(3'(m));
        end
        // Prohibit aborts a move in progress.
        wr(`IPC_OFS_CTRL, 32'h0000_2201);
        wr(`IPC_OFS_LENGTH, 32'h0000_0FFF);
        u_host.pin(3, 1'b1, 12);
        check(move.move_active, 1'b1, "running");
        u_host.pin(0, 1'b1, 8);
        check(move.override_active, 1'b0, "abort");
        check(move.move_done, 1'b0, "done on abort");
        rdc(`IPC_OFS_INT_STAT, 32'h5, "abort status");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
